// [logic/icd_pkg.sv]
// Package of constants and types for the instruction decode core
package icd_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W = 32;
	localparam int unsigned CLS_W  = 6;
	localparam int unsigned REG_W  = 5;
	localparam int unsigned IMM_W  = 16;
	localparam int unsigned JT_W   = 26;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned CLS_HI = 31;
	localparam int unsigned CLS_LO = 26;
	localparam int unsigned RS_HI  = 25;
	localparam int unsigned RS_LO  = 21;
	localparam int unsigned RT_HI  = 20;
	localparam int unsigned RT_LO  = 16;
	localparam int unsigned RD_HI  = 15;
	localparam int unsigned RD_LO  = 11;
	localparam int unsigned SH_HI  = 10;
	localparam int unsigned SH_LO  = 6;
	localparam int unsigned SEC_HI = 5;
	localparam int unsigned SEC_LO = 0;
	localparam int unsigned IMM_HI = 15;
	localparam int unsigned JT_HI  = 25;
	localparam int unsigned PC_SEG_LO = 28;

	// ----------------------------------------------------------------
	// Major class and secondary codes
	// ----------------------------------------------------------------
	localparam logic [5:0] CLS_REGFMT = 6'h00;
	localparam logic [5:0] CLS_REGIMM = 6'h01;
	localparam logic [5:0] CLS_J      = 6'h02;
	localparam logic [5:0] CLS_JAL    = 6'h03;
	localparam logic [5:0] SEC_JR     = 6'h08;
	localparam logic [5:0] SEC_JALR   = 6'h09;
	localparam logic [5:0] SEC_SYSC   = 6'h0C;
	localparam logic [5:0] SEC_BRK    = 6'h0D;
	localparam logic [5:0] SEC_RD_UP  = 6'h10;
	localparam logic [5:0] SEC_RD_BOT = 6'h12;
	localparam logic [5:0] SEC_MUL_S  = 6'h18;
	localparam logic [5:0] SEC_MUL_U  = 6'h19;

	// Unassigned major classes and register-format secondary codes
	localparam logic [63:0] CLS_UNASSIGNED = 64'hD8D0_3080_4F00_0000;
	localparam logic [63:0] SEC_UNASSIGNED = 64'hFFA0_F300_F0F0_4020;

	// ----------------------------------------------------------------
	// Timing and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  MUL_CYCLES = 3'h3;
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ICD_FMT_IMM, ICD_FMT_JUMP, ICD_FMT_REG} icd_fmt_t;
	typedef enum logic [2:0] {
		ICD_SZ_NONE, ICD_SZ_BYTE, ICD_SZ_HALF, ICD_SZ_TRIPLE, ICD_SZ_WORD
	} icd_size_t;

endpackage

// [logic/icd_lane_if.sv]
// Interface carrying an access request to the byte-lane selector
`timescale 1ns/1ns
interface icd_lane_if;
	import icd_pkg::*;
	icd_size_t  size;
	logic [2:0] addr_lo;
	logic       big_endian;
	logic [3:0] byte_en;
	logic       addr_err;
	modport req (output size, output addr_lo, output big_endian,
		input byte_en, input addr_err);
	modport sel (input size, input addr_lo, input big_endian,
		output byte_en, output addr_err);
endinterface

// [logic/icd_lane_sel.sv]
// Byte-lane selection and address error check for data accesses
`timescale 1ns/1ns
module icd_lane_sel
	import icd_pkg::*;
(
	icd_lane_if.sel lane
);
	wire       off0 = (lane.addr_lo == 3'h0);
	wire       off1 = (lane.addr_lo == 3'h1);
	wire       off2 = (lane.addr_lo == 3'h2);
	wire       in_w = (lane.addr_lo[2] == 1'b0);
	wire [3:0] byte_le = 4'h1 << lane.addr_lo[1:0];
	logic [3:0] le_lanes;
	logic       ok;

	// Lanes in little-endian numbering; bit n covers data bits 8n+7..8n
	always_comb begin
		le_lanes = 4'h0;
		ok       = 1'b0;
		case (lane.size)
			ICD_SZ_WORD: begin
				ok       = off0;
				le_lanes = 4'hF;
			end
			ICD_SZ_TRIPLE: begin
				ok       = off0 | off1;
				le_lanes = off1 ? 4'hE : 4'h7;
			end
			ICD_SZ_HALF: begin
				ok       = off0 | off2;
				le_lanes = off2 ? 4'hC : 4'h3;
			end
			ICD_SZ_BYTE: begin
				ok       = in_w;
				le_lanes = byte_le;
			end
			default: begin
				ok       = 1'b1;
				le_lanes = 4'h0;
			end
		endcase
	end

	// Big-endian mirrors the lanes so the address names the high byte
	wire [3:0] be_lanes = {le_lanes[0], le_lanes[1], le_lanes[2], le_lanes[3]};

	assign lane.addr_err = ~ok;
	assign lane.byte_en  = ok ? (lane.big_endian ? be_lanes : le_lanes) : 4'h0;
endmodule // icd_lane_sel

// [logic/icd_decode_core.sv]
// Instruction decode core: fields, interlocks, targets and byte lanes
//
// Overview of operation
// - Every instruction is one aligned 32-bit word; immediate, jump, register formats.
// - Major class and secondary opcode fields are 6 bits wide.
// - First source, second operand, destination, shift amount are 5 bits each.
// - Jump format carries 26-bit target; immediate format carries 16-bit value.
// - Use of a loaded register right after the load stalls in hardware.
// - Effective address names the high-order or low-order byte, per endianness.
// - Lanes follow size and address bits 2..0 within the permitted set.
// - Illegal size and offset pairs skip the access and raise address error.
// - Multiply runs in a separate unit; result lands in product halves.
// - Reading a product half before it is ready stalls the pipeline.
// - Each jump or branch has exactly one delay-slot instruction.
// - Jump target is field shifted by 2 under upper 4 PC bits.
// - Register jumps take the full 32-bit register value as target.
// - Branch target is delay-slot address plus sign-extended offset times four.
// - Not-taken branch-likely nullifies its delay-slot instruction.
// - Trap-initiating control instructions decode only in register format.
// - Unassigned encodings raise reserved instruction exception.
`timescale 1ns/1ns
module icd_decode_core
	import icd_pkg::*;
(
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	// Instruction in
	input  wire logic               i_valid,
	input  wire logic [WORD_W-1:0]  i_instr,
	input  wire logic [WORD_W-1:0]  i_pc,
	input  wire logic [WORD_W-1:0]  i_rs_value,
	input  wire logic [WORD_W-1:0]  i_rt_value,
	input  wire logic               i_big_endian,
	output logic                    o_ready,
	output logic                    o_stall,
	// Decoded fields
	output logic                    o_valid,
	output icd_fmt_t                o_format,
	output logic [CLS_W-1:0]        o_major_instruction_class_field,
	output logic [REG_W-1:0]        o_first_source_field,
	output logic [REG_W-1:0]        o_second_operand_field,
	output logic [REG_W-1:0]        o_dest_field,
	output logic [REG_W-1:0]        o_shift_amount_field,
	output logic [CLS_W-1:0]        o_secondary_field,
	output logic [IMM_W-1:0]        o_immediate,
	output logic [JT_W-1:0]         o_jump_field,
	// Exceptions
	output logic                    o_fetch_align_err,
	output logic                    o_reserved,
	output logic                    o_trap,
	// Control flow
	output logic                    o_redirect,
	output logic                    o_link,
	output logic [WORD_W-1:0]       o_target,
	output logic                    o_delay_slot,
	output logic                    o_nullify,
	// Data access
	output logic                    o_mem_en,
	output logic                    o_mem_write,
	output logic [WORD_W-1:0]       o_eff_addr,
	output logic [3:0]              o_byte_en,
	output logic                    o_addr_err,
	// Product halves
	output logic [WORD_W-1:0]       o_product_upper_half,
	output logic [WORD_W-1:0]       o_product_bottom_half
);

	// ----------------------------------------------------------------
	// Field split
	// ----------------------------------------------------------------
	wire [CLS_W-1:0] cls = i_instr[CLS_HI:CLS_LO];
	wire [REG_W-1:0] rs  = i_instr[RS_HI:RS_LO];
	wire [REG_W-1:0] rt  = i_instr[RT_HI:RT_LO];
	wire [REG_W-1:0] rd  = i_instr[RD_HI:RD_LO];
	wire [REG_W-1:0] sh  = i_instr[SH_HI:SH_LO];
	wire [CLS_W-1:0] sec = i_instr[SEC_HI:SEC_LO];
	wire [IMM_W-1:0] imm = i_instr[IMM_HI:0];
	wire [JT_W-1:0]  jt  = i_instr[JT_HI:0];

	// ----------------------------------------------------------------
	// Class decode
	// ----------------------------------------------------------------
	wire is_regfmt = (cls == CLS_REGFMT);
	wire is_regimm = (cls == CLS_REGIMM);
	wire is_jfmt   = (cls == CLS_J) | (cls == CLS_JAL);
	wire is_jreg   = is_regfmt & ((sec == SEC_JR) | (sec == SEC_JALR));
	wire is_trap   = is_regfmt & ((sec[5:3] == 3'h6) | (sec == SEC_SYSC)
		| (sec == SEC_BRK));
	wire is_mul    = is_regfmt & ((sec == SEC_MUL_S) | (sec == SEC_MUL_U));
	wire is_rdprod = is_regfmt & ((sec == SEC_RD_UP) | (sec == SEC_RD_BOT));
	wire rsv_cls   = CLS_UNASSIGNED[cls];
	wire rsv_sec   = is_regfmt & SEC_UNASSIGNED[sec];
	wire reserved  = rsv_cls | rsv_sec;
	wire fetch_bad = (i_pc[1:0] != 2'b00);

	// Branches: classes 4..7 and 20..23, plus immediate-branch group
	wire br_cmp    = (cls[5] == 1'b0) & (cls[3] == 1'b0) & cls[2];
	wire br_imm    = is_regimm & (rt[3:2] == 2'b00);
	wire is_branch = br_cmp | br_imm;
	wire likely    = br_cmp ? cls[4] : rt[1];
	wire rs_neg    = i_rs_value[WORD_W-1];
	wire rs_zero   = (i_rs_value == WORD_RST);
	wire rs_eq_rt  = (i_rs_value == i_rt_value);
	logic cmp_true;

	always_comb begin
		case (cls[1:0])
			2'h0:    cmp_true = rs_eq_rt;
			2'h1:    cmp_true = ~rs_eq_rt;
			2'h2:    cmp_true = rs_neg | rs_zero;
			default: cmp_true = ~rs_neg & ~rs_zero;
		endcase
	end

	wire br_true = br_cmp ? cmp_true : (rt[0] ? ~rs_neg : rs_neg);
	wire taken   = is_jfmt | is_jreg | (is_branch & br_true);
	wire linking = (cls == CLS_JAL) | (is_regfmt & (sec == SEC_JALR))
		| (br_imm & rt[4]);

	// ----------------------------------------------------------------
	// Targets
	// ----------------------------------------------------------------
	wire [WORD_W-1:0] slot_addr = i_pc + 32'h0000_0004;
	wire [WORD_W-1:0] br_off    = {{14{imm[IMM_W-1]}}, imm, 2'b00};
	wire [WORD_W-1:0] br_tgt    = slot_addr + br_off;
	wire [WORD_W-1:0] j_tgt     = {i_pc[WORD_W-1:PC_SEG_LO], jt, 2'b00};
	wire [WORD_W-1:0] target    = is_jfmt ? j_tgt
		: (is_jreg ? i_rs_value : br_tgt);

	// ----------------------------------------------------------------
	// Data access size
	// ----------------------------------------------------------------
	wire is_load  = (cls[5:3] == 3'h4) | (cls == 6'h30);
	wire is_store = (cls[5:3] == 3'h5) | (cls == 6'h38);
	icd_size_t acc_size;

	// Partial-word left/right forms carry no fixed lane set here
	always_comb begin
		case (cls)
			6'h20, 6'h24, 6'h28: acc_size = ICD_SZ_BYTE;
			6'h21, 6'h25, 6'h29: acc_size = ICD_SZ_HALF;
			6'h23, 6'h2B, 6'h30, 6'h38: acc_size = ICD_SZ_WORD;
			default: acc_size = ICD_SZ_NONE;
		endcase
	end

	wire [WORD_W-1:0] eff_addr = i_rs_value + {{16{imm[IMM_W-1]}}, imm};
	wire              is_mem   = acc_size != ICD_SZ_NONE;

	icd_lane_if lane ();
	assign lane.size       = acc_size;
	assign lane.addr_lo    = eff_addr[2:0];
	assign lane.big_endian = i_big_endian;

	icd_lane_sel u_lane (
		.lane (lane.sel)
	);

	// ----------------------------------------------------------------
	// Interlocks
	// ----------------------------------------------------------------
	logic             ld_pend_q;
	logic [REG_W-1:0] ld_dest_q;
	logic [2:0]       mul_cnt_q;
	logic [63:0]      mul_res_q;
	logic             slot_next_q;
	logic             null_next_q;

	wire ld_hit   = ld_pend_q & (ld_dest_q != 5'h00)
		& ((rs == ld_dest_q) | (rt == ld_dest_q));
	wire mul_busy = (mul_cnt_q != 3'h0);
	// A second multiply also waits, so one result is never overwritten
	wire mul_hit  = mul_busy & (is_rdprod | is_mul);
	wire stall    = i_valid & (ld_hit | mul_hit);
	wire accept   = i_valid & ~stall;

	assign o_stall = stall;
	assign o_ready = ~stall;

	wire        mul_sgn = (sec == SEC_MUL_S);
	wire [32:0] mul_a   = {mul_sgn & i_rs_value[WORD_W-1], i_rs_value};
	wire [32:0] mul_b   = {mul_sgn & i_rt_value[WORD_W-1], i_rt_value};
	wire [65:0] mul_p   = $signed(mul_a) * $signed(mul_b);

	// ----------------------------------------------------------------
	// Interlock and multiplier state
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ld_pend_q <= 1'b0;
			ld_dest_q <= 5'h00;
		end else begin
			// A stall cycle issues a bubble, which ends the hazard
			ld_pend_q <= accept & is_load;
			ld_dest_q <= rt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			mul_cnt_q             <= 3'h0;
			mul_res_q             <= 64'h0000_0000_0000_0000;
			o_product_upper_half  <= WORD_RST;
			o_product_bottom_half <= WORD_RST;
		end else if (accept & is_mul & ~reserved & ~fetch_bad & ~(slot_next_q & null_next_q)) begin
			mul_cnt_q <= MUL_CYCLES;
			mul_res_q <= mul_p[63:0];
		end else if (mul_busy) begin
			mul_cnt_q <= mul_cnt_q - 3'h1;
			if (mul_cnt_q == 3'h1) begin
				o_product_upper_half  <= mul_res_q[63:32];
				o_product_bottom_half <= mul_res_q[31:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Delay slot tracking
	// ----------------------------------------------------------------
	wire xfer = is_jfmt | is_jreg | is_branch;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			slot_next_q <= 1'b0;
			null_next_q <= 1'b0;
		end else if (accept) begin
			slot_next_q <= xfer & ~reserved & ~fetch_bad;
			null_next_q <= is_branch & likely & ~br_true;
		end
	end

	// ----------------------------------------------------------------
	// Decoded outputs
	// ----------------------------------------------------------------
	wire ok_exec = accept & ~reserved & ~fetch_bad;
	wire killed  = slot_next_q & null_next_q;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_valid                         <= 1'b0;
			o_format                        <= ICD_FMT_IMM;
			o_major_instruction_class_field <= 6'h00;
			o_first_source_field            <= 5'h00;
			o_second_operand_field          <= 5'h00;
			o_dest_field                    <= 5'h00;
			o_shift_amount_field            <= 5'h00;
			o_secondary_field               <= 6'h00;
			o_immediate                     <= 16'h0000;
			o_jump_field                    <= 26'h000_0000;
		end else begin
			o_valid <= accept;
			if (accept) begin
				o_format <= is_jfmt ? ICD_FMT_JUMP
					: (is_regfmt ? ICD_FMT_REG : ICD_FMT_IMM);
				o_major_instruction_class_field <= cls;
				o_first_source_field            <= rs;
				o_second_operand_field          <= rt;
				o_dest_field                    <= rd;
				o_shift_amount_field            <= sh;
				o_secondary_field               <= sec;
				o_immediate                     <= imm;
				o_jump_field                    <= jt;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_fetch_align_err <= 1'b0;
			o_reserved        <= 1'b0;
			o_trap            <= 1'b0;
			o_redirect        <= 1'b0;
			o_link            <= 1'b0;
			o_target          <= WORD_RST;
			o_delay_slot      <= 1'b0;
			o_nullify         <= 1'b0;
		end else begin
			o_fetch_align_err <= accept & fetch_bad;
			o_reserved        <= accept & ~fetch_bad & reserved;
			o_trap            <= ok_exec & ~killed & is_trap;
			o_redirect        <= ok_exec & ~killed & taken;
			o_link            <= ok_exec & ~killed & linking;
			o_delay_slot      <= accept & slot_next_q;
			o_nullify         <= accept & killed;
			if (accept) begin
				o_target <= target;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_mem_en    <= 1'b0;
			o_mem_write <= 1'b0;
			o_eff_addr  <= WORD_RST;
			o_byte_en   <= 4'h0;
			o_addr_err  <= 1'b0;
		end else begin
			o_mem_en    <= ok_exec & ~killed & is_mem & ~lane.addr_err;
			o_mem_write <= ok_exec & ~killed & is_mem & is_store & ~lane.addr_err;
			o_addr_err  <= ok_exec & ~killed & is_mem & lane.addr_err;
			if (accept) begin
				o_eff_addr <= eff_addr;
				o_byte_en  <= (is_mem & ~killed) ? lane.byte_en : 4'h0;
			end
		end
	end

endmodule // icd_decode_core

// [verification/icd_decode_core_asserts.sv]
// Port checker for the instruction decode core
`timescale 1ns/1ns
module icd_decode_core_chk
	import icd_pkg::*;
(
	// Clock and reset
	input wire logic		i_clk,
	input wire logic		i_reset_n,
	// Instruction side
	input wire logic		i_valid,
	input wire logic [WORD_W-1:0]	i_instr,
	input wire logic [WORD_W-1:0]	i_pc,
	input wire logic [WORD_W-1:0]	i_rs_value,
	input wire logic [WORD_W-1:0]	i_rt_value,
	input wire logic		o_ready,
	input wire logic		o_stall,
	// Results
	input wire logic		o_valid,
	input wire icd_fmt_t		o_format,
	input wire logic [CLS_W-1:0]	o_major_instruction_class_field,
	input wire logic [IMM_W-1:0]	o_immediate,
	input wire logic		o_trap,
	input wire logic		o_redirect,
	input wire logic [WORD_W-1:0]	o_target,
	input wire logic		o_delay_slot,
	input wire logic		o_nullify,
	input wire logic		o_mem_en,
	input wire logic [3:0]		o_byte_en,
	input wire logic		o_addr_err
);
	// --------
	// Decode of the offered word
	// --------
	wire		acc = i_valid && o_ready;
	wire [5:0]	cls = i_instr[31:26];
	wire [5:0]	sec = i_instr[5:0];
	wire		ok = acc && i_pc[1:0] == 2'h0;
	wire		ld = ok && cls == 6'h23 && i_instr[20:16] != 5'h00;
	wire		mul = ok && cls == 6'h00 && sec[5:1] == 5'h0C;
	wire		rdp = i_valid && cls == 6'h00 && (sec == SEC_RD_UP || sec == SEC_RD_BOT);
	wire [31:0]	btgt = i_pc + 32'h4 + {{14{i_instr[15]}}, i_instr[15:0], 2'h0};

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// --------
	// Assertions
	// --------
	chk_load_use: assert property (ld ##1 (i_valid && i_instr[25:21] == $past(i_instr[20:16]))
		|-> o_stall) else $error("load-use stall missing");
	chk_product_wait: assert property (mul ##1 (rdp && !o_nullify) |-> o_stall[*3] ##1 o_ready)
		else $error("product read wait wrong");
	chk_valid_take: assert property (o_valid == $past(acc && i_reset_n))
		else $error("valid does not follow acceptance");
	chk_field_take: assert property (acc |=> o_major_instruction_class_field == $past(cls)
		&& o_immediate == $past(i_instr[15:0])) else $error("field capture wrong");
	chk_jump_target: assert property (ok && cls[5:1] == 5'h01 |=> o_nullify || o_redirect
		&& o_target == {$past(i_pc[31:28]), $past(i_instr[25:0]), 2'h0})
		else $error("jump target wrong");
	chk_reg_jump: assert property (ok && cls == 6'h00 && sec == SEC_JR |=> o_nullify
		|| o_redirect && o_target == $past(i_rs_value)) else $error("register jump wrong");
	chk_branch_target: assert property (ok && cls == 6'h04 && i_rs_value == i_rt_value
		|=> o_nullify || o_redirect && o_target == $past(btgt)) else $error("branch wrong");
	chk_err_no_access: assert property (o_addr_err |-> !o_mem_en && o_byte_en == 4'h0)
		else $error("access made despite address error");
	chk_nullify_quiet: assert property (o_nullify |-> o_delay_slot && !o_redirect
		&& !o_mem_en && !o_trap) else $error("nullified slot had an effect");
	chk_trap_format: assert property (o_trap |-> o_format == ICD_FMT_REG)
		else $error("trap outside register format");

	cov_load_stall: cover property (ld ##1 o_stall);
	cov_mul_stall: cover property (mul ##1 o_stall[*3]);
	cov_nullify: cover property (o_nullify);
endmodule // icd_decode_core_chk

bind icd_decode_core icd_decode_core_chk icd_decode_core_chk_i (.i_clk, .i_reset_n, .i_valid,
	.i_instr, .i_pc, .i_rs_value, .i_rt_value, .o_ready, .o_stall, .o_valid, .o_format,
	.o_major_instruction_class_field, .o_immediate, .o_trap, .o_redirect, .o_target,
	.o_delay_slot, .o_nullify, .o_mem_en, .o_byte_en, .o_addr_err);

// [verification/icd_imem_model.sv]
// Instruction memory model offering a short program to the decode core
`timescale 1ns/1ns
module icd_imem_model
	import icd_pkg::*;
(
	// Clock
	input  wire logic		i_clk,
	// Offer to the core
	input  wire logic		i_ready,
	output logic			o_valid,
	output logic [WORD_W-1:0]	o_instr,
	output logic [WORD_W-1:0]	o_pc
);
	logic [WORD_W-1:0]	prog [16];
	logic [WORD_W-1:0]	base;
	int			ptr;
	int			len;
	logic			taken;

	function automatic logic xfer(input logic [WORD_W-1:0] w);
		return w[31:26] inside {[6'h01:6'h07], [6'h14:6'h17]} || w[31:26] == 6'h00 && w[5:1] == 5'h04;
	endfunction

	// A transfer in a delay slot is refused rather than stored
	task automatic put(input int k, input logic [WORD_W-1:0] w);
		if (k > 0 && xfer(prog[k-1]) && xfer(w))
			$display("model refuses a transfer in a delay slot");
		else
			prog[k] = w;
	endtask

	task automatic start(input int n, input logic [WORD_W-1:0] b);
		base = b;
		ptr = 0;
		len = n;
	endtask

	initial begin
		o_valid = 1'b0;
		o_instr = 32'h0;
		o_pc = 32'h0;
		ptr = 0;
		len = 0;
		taken = 1'b0;
	end

	// A word moves on only once the core took it; an idle bus inverts the last word each cycle
	always @(posedge i_clk) taken <= o_valid && i_ready;
	always @(negedge i_clk) begin
		if (taken)
			ptr = ptr + 1;
		o_valid = ptr < len;
		o_instr = (ptr < len) ? prog[ptr] : ~o_instr;
		o_pc = base + 32'(4 * ptr);
	end
endmodule // icd_imem_model

// [verification/testbench.sv]
// Self-checking testbench for the instruction decode core
`timescale 1ns/1ns
module testbench
	import icd_pkg::*;
;
	logic			i_clk, i_reset_n, i_valid, i_big_endian;
	logic [WORD_W-1:0]	i_instr, i_pc, i_rs_value, i_rt_value;
	logic			o_ready, o_stall, o_valid, o_fetch_align_err, o_reserved, o_trap;
	logic			o_redirect, o_link, o_delay_slot, o_nullify, o_mem_en, o_mem_write;
	logic			o_addr_err;
	icd_fmt_t		o_format;
	logic [CLS_W-1:0]	o_major_instruction_class_field, o_secondary_field;
	logic [REG_W-1:0]	o_first_source_field, o_second_operand_field;
	logic [REG_W-1:0]	o_dest_field, o_shift_amount_field;
	logic [IMM_W-1:0]	o_immediate;
	logic [JT_W-1:0]	o_jump_field;
	logic [WORD_W-1:0]	o_target, o_eff_addr, o_product_upper_half, o_product_bottom_half;
	logic [3:0]		o_byte_en;
	int			n_fail, checks_done, n_stall;
	localparam logic [31:0]	NOP = 32'h0000_0020;

	icd_decode_core icd_decode_core_i (.i_clk, .i_reset_n, .i_valid, .i_instr, .i_pc,
		.i_rs_value, .i_rt_value, .i_big_endian, .o_ready, .o_stall, .o_valid, .o_format,
		.o_major_instruction_class_field, .o_first_source_field, .o_second_operand_field,
		.o_dest_field, .o_shift_amount_field, .o_secondary_field, .o_immediate,
		.o_jump_field, .o_fetch_align_err, .o_reserved, .o_trap, .o_redirect, .o_link,
		.o_target, .o_delay_slot, .o_nullify, .o_mem_en, .o_mem_write, .o_eff_addr,
		.o_byte_en, .o_addr_err, .o_product_upper_half, .o_product_bottom_half);
	icd_imem_model icd_imem_model_i (.i_clk, .i_ready(o_ready), .o_valid(i_valid),
		.o_instr(i_instr), .o_pc(i_pc));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_stall === 1'b1) n_stall++;

	// --------
	// Shared tasks
	// --------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic put(input int k, input logic [31:0] w);
		icd_imem_model_i.put(k, w);
	endtask

	task automatic go(input int n, input logic [31:0] pc, rs, rt, input logic big);
		@(negedge i_clk);
		i_rs_value = rs;
		i_rt_value = rt;
		i_big_endian = big;
		n_stall = 0;
		icd_imem_model_i.start(n, pc);
	endtask

	// Bounded wait for the next decode result
	task automatic next();
		int k;
		k = 0;
		do begin
			@(negedge i_clk);
			#1;
			k++;
		end while (o_valid !== 1'b1 && k < 20);
		if (o_valid !== 1'b1) begin
			check("o_valid", o_valid, 1'b1);
			conclude();
		end
	endtask

	// --------
	// Scenarios
	// --------
	task automatic sc_fields();
		put(0, {6'h00, 5'h11, 5'h0A, 5'h15, 5'h0B, 6'h20});
		put(1, {CLS_JAL, 26'h2AB_CDEF});
		put(2, NOP);
		put(3, {6'h08, 5'h03, 5'h04, 16'h8001});
		go(4, 32'hA000_0100, 32'h0, 32'h0, 1'b0);
		next();
		check("format", o_format, ICD_FMT_REG);
		check("class", o_major_instruction_class_field, 6'h00);
		check("secondary", o_secondary_field, 6'h20);
		check("source", o_first_source_field, 5'h11);
		check("operand", o_second_operand_field, 5'h0A);
		check("dest", o_dest_field, 5'h15);
		check("shift", o_shift_amount_field, 5'h0B);
		next();
		check("jump field", o_jump_field, 26'h2AB_CDEF);
		check("jump target", o_target, {4'hA, 26'h2AB_CDEF, 2'h0});
		check("jump taken", o_redirect, 1'b1);
		check("jump link", o_link, 1'b1);
		next();
		check("slot", o_delay_slot, 1'b1);
		next();
		check("imm format", o_format, ICD_FMT_IMM);
		check("immediate", o_immediate, 16'h8001);
		check("slot end", o_delay_slot, 1'b0);
	endtask

	task automatic sc_excepts();
		logic [31:0] w [5] = '{32'h0000_000C, 32'h0000_000D, 32'h0000_0034, 32'h6000_0000,
			32'h0000_0005};
		for (int k = 0; k < 5; k++) begin
			put(0, w[k]);
			go(1, 32'h0000_0200, 32'h0, 32'h0, 1'b0);
			next();
			check("trap", o_trap, k < 3);
			check("reserved", o_reserved, k > 2);
		end
		put(0, NOP);
		go(1, 32'h0000_0102, 32'h0, 32'h0, 1'b0);
		next();
		check("align", o_fetch_align_err, 1'b1);
	endtask

	task automatic sc_lanes();
		logic [5:0] cls [3] = '{6'h20, 6'h21, 6'h23};
		int sz;
		logic [3:0] en;
		logic err;
		for (int b = 0; b < 2; b++) begin
			for (int s = 0; s < 3; s++) begin
				for (int o = 0; o < 4; o++) begin
					sz = 1 << s;
					err = o % sz != 0;
					en = 4'(((1 << sz) - 1) << o);
					if (b == 1)
						en = {en[0], en[1], en[2], en[3]};
					put(0, {cls[s] | 6'(b * 8), 5'h01, 5'h02, 14'h0, 2'(o)});
					go(1, 32'h0000_0300, 32'h0000_2000, 32'h0, b[0]);
					next();
					check("addr error", o_addr_err, err);
					check("mem enable", o_mem_en, !err);
					check("mem write", o_mem_write, !err && b == 1);
					check("lanes", o_byte_en, err ? 4'h0 : en);
					if (!err)
						check("address", o_eff_addr, 32'h0000_2000 + o);
				end
			end
		end
	endtask

	task automatic sc_interlocks();
		put(0, {6'h23, 5'h01, 5'h05, 16'h0010});
		put(1, {6'h00, 5'h05, 5'h06, 5'h07, 5'h00, 6'h20});
		go(2, 32'h0000_0400, 32'h0000_1000, 32'h0, 1'b0);
		next();
		next();
		check("load stall", n_stall, 1);
		put(0, {6'h00, 5'h07, 5'h08, 10'h000, SEC_MUL_U});
		put(1, {16'h0000, 5'h09, 5'h00, SEC_RD_UP});
		put(2, {16'h0000, 5'h0A, 5'h00, SEC_RD_BOT});
		go(3, 32'h0000_0500, 32'hFFFF_FFFF, 32'h0000_0002, 1'b0);
		next();
		next();
		check("product wait", n_stall, 3);
		check("upper", o_product_upper_half, 32'h0000_0001);
		check("bottom", o_product_bottom_half, 32'hFFFF_FFFE);
		next();
		check("no extra wait", n_stall, 3);
	endtask

	task automatic sc_branches();
		put(0, {6'h04, 5'h01, 5'h02, 16'hFFFE});
		put(1, NOP);
		put(2, {6'h15, 5'h01, 5'h02, 16'h0004});
		put(3, {6'h2B, 5'h01, 5'h02, 16'h0000});
		put(4, NOP);
		put(5, {6'h00, 5'h04, 15'h0000, SEC_JR});
		put(6, NOP);
		go(7, 32'h0000_0100, 32'h0000_0010, 32'h0000_0010, 1'b0);
		next();
		check("branch target", o_target, 32'h0000_00FC);
		next();
		check("slot", o_delay_slot, 1'b1);
		check("kept", o_nullify, 1'b0);
		next();
		check("likely", o_redirect, 1'b0);
		next();
		check("nullified", o_nullify, 1'b1);
		check("no store", o_mem_en, 1'b0);
		check("no write", o_mem_write, 1'b0);
		next();
		check("one slot", o_delay_slot, 1'b0);
		next();
		check("reg jump", o_redirect, 1'b1);
		check("reg target", o_target, 32'h0000_0010);
		check("reg no link", o_link, 1'b0);
		next();
	endtask

	initial begin
		i_reset_n = 1'b0;
		i_big_endian = 1'b0;
		i_rs_value = 32'h0;
		i_rt_value = 32'h0;
		n_fail = 0;
		checks_done = 0;
		n_stall = 0;
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
		sc_fields();
		sc_excepts();
		sc_lanes();
		sc_interlocks();
		sc_branches();
		conclude();
	end
endmodule // testbench
